// file: verilog/clsd_defs.vh
// Constants for the compact load/store decoder: opcode groups, field positions, timing.
// Assumes inclusion by bare name from the design files.
`ifndef CLSD_DEFS_VH
`define CLSD_DEFS_VH

// ----------------------------------------------------------------------------
// Group codes and field positions
// ----------------------------------------------------------------------------
`define CLSD_GRP_IMM      3'h3
`define CLSD_GRP_HALF     4'h8
`define CLSD_GRP_SP       4'h9
`define CLSD_GRP_LDA      4'hA
`define CLSD_BIT_BYTE     12
`define CLSD_BIT_LOAD     11
`define CLSD_BIT_SEL      11
`define CLSD_IMM5_HI      10
`define CLSD_IMM5_LO      6
`define CLSD_BASE_HI      5
`define CLSD_BASE_LO      3
`define CLSD_RD_HI        2
`define CLSD_RD_LO        0
`define CLSD_RD8_HI       10
`define CLSD_RD8_LO       8
`define CLSD_IMM8_HI      7
`define CLSD_IMM8_LO      0
`define CLSD_SHIFT_WORD   2
`define CLSD_SHIFT_HALF   1
`define CLSD_PC_AHEAD     32'h00000004
`define CLSD_PC_BIT1      1

// ----------------------------------------------------------------------------
// Size codes and timing
// ----------------------------------------------------------------------------
`define CLSD_SIZE_BYTE    2'h0
`define CLSD_SIZE_HALF    2'h1
`define CLSD_SIZE_WORD    2'h2
`define CLSD_MEM_CYCLES   2'h2
`define CLSD_ALU_CYCLES   2'h1
`define CLSD_RST_INSN     16'h0000
`define CLSD_RST_WORD     32'h00000000

`endif

// file: verilog/clsd_field_scale.v
// Zero-extends an immediate field and scales it by a left shift.
// Assumes a constant shift amount; pure combinational.
`timescale 1ns/1ps
`default_nettype none

module clsd_field_scale #(
    parameter IN_W  = 5,
    parameter SHIFT = 2
) (
    // Field in
    input  wire [IN_W-1:0] field_in,
    // Scaled byte offset
    output wire [31:0]     offset_out
);

    // ------------------------------------------------------------------------
    // Scale
    // ------------------------------------------------------------------------
    // Zero-extend first so the shift loses no bits
    wire [31:0] ext_w;
    assign ext_w      = {{(32-IN_W){1'b0}}, field_in};
    assign offset_out = ext_w << SHIFT;

endmodule // clsd_field_scale

`default_nettype wire

// file: verilog/clsd_decoder.v
// Compact load/store decoder: immediate, half-word, stack-relative and load-address groups.
// Assumes the register file reads combinationally and memory answers with MEM_DONE_IN.
`timescale 1ns/1ps
`default_nettype none
`include "clsd_defs.vh"

module clsd_decoder (
    // Clock and reset
    input  wire        REF_CLK_IN,
    input  wire        RST_N_IN,
    // Fetch side
    input  wire        INSN_VALID_IN,
    input  wire [15:0] INSN_IN,
    input  wire [31:0] INSN_ADDR_IN,
    output wire        INSN_READY_OUT,
    output wire        INSN_ILLEGAL_OUT,
    // Register file read
    output reg  [2:0]  RD_SEL_A_OUT,
    output reg  [2:0]  RD_SEL_B_OUT,
    input  wire [31:0] RD_DATA_A_IN,
    input  wire [31:0] RD_DATA_B_IN,
    input  wire [31:0] SP_VALUE_IN,
    // Register file write
    output reg         WR_EN_OUT,
    output reg  [2:0]  WR_SEL_OUT,
    output reg  [31:0] WR_DATA_OUT,
    // Condition flags
    output wire        FLAGS_WR_EN_OUT,
    // Memory interface
    output reg         MEM_REQ_OUT,
    output reg         MEM_WRITE_OUT,
    output reg  [1:0]  MEM_SIZE_OUT,
    output reg  [3:0]  MEM_BYTE_EN_OUT,
    output reg  [31:0] MEM_ADDR_OUT,
    output reg  [31:0] MEM_WDATA_OUT,
    input  wire        MEM_DONE_IN,
    input  wire [31:0] MEM_RDATA_IN,
    // Completion
    output reg         DONE_OUT
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_MEM  = 3'h2;
    localparam [2:0] ST_WB   = 3'h4;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;

    // ------------------------------------------------------------------------
    // Group decode
    // ------------------------------------------------------------------------
    wire is_imm  = (INSN_IN[15:13] == `CLSD_GRP_IMM);
    wire is_half = (INSN_IN[15:12] == `CLSD_GRP_HALF);
    wire is_sp   = (INSN_IN[15:12] == `CLSD_GRP_SP);
    wire is_lda  = (INSN_IN[15:12] == `CLSD_GRP_LDA);
    wire known   = is_imm | is_half | is_sp | is_lda;

    wire bit_byte = INSN_IN[`CLSD_BIT_BYTE];
    wire bit_load = INSN_IN[`CLSD_BIT_LOAD];
    wire bit_sel  = INSN_IN[`CLSD_BIT_SEL];

    wire [4:0] imm5_offset_field = INSN_IN[`CLSD_IMM5_HI:`CLSD_IMM5_LO];
    wire [7:0] imm8_word_field   = INSN_IN[`CLSD_IMM8_HI:`CLSD_IMM8_LO];
    wire [2:0] base_reg_field    = INSN_IN[`CLSD_BASE_HI:`CLSD_BASE_LO];
    wire [2:0] rd_low            = INSN_IN[`CLSD_RD_HI:`CLSD_RD_LO];
    wire [2:0] rd_high           = INSN_IN[`CLSD_RD8_HI:`CLSD_RD8_LO];
    wire [2:0] low_eight_register = (is_sp | is_lda) ? rd_high : rd_low;

    // ------------------------------------------------------------------------
    // Offset scaling
    // ------------------------------------------------------------------------
    wire [31:0] off_byte;
    wire [31:0] off_word;
    wire [31:0] off_half;
    wire [31:0] off_w8;

    // Byte offsets used as is, 0 to 31
    clsd_field_scale #(.IN_W(5), .SHIFT(0)) u_off_byte (
        .field_in   (imm5_offset_field),
        .offset_out (off_byte)
    );
    // Word offsets up to 124
    clsd_field_scale #(.IN_W(5), .SHIFT(`CLSD_SHIFT_WORD)) u_off_word (
        .field_in   (imm5_offset_field),
        .offset_out (off_word)
    );
    // Half-word offsets, bit 0 always zero
    clsd_field_scale #(.IN_W(5), .SHIFT(`CLSD_SHIFT_HALF)) u_off_half (
        .field_in   (imm5_offset_field),
        .offset_out (off_half)
    );
    // Stack and load-address constants up to 1020
    clsd_field_scale #(.IN_W(8), .SHIFT(`CLSD_SHIFT_WORD)) u_off_w8 (
        .field_in   (imm8_word_field),
        .offset_out (off_w8)
    );

    // ------------------------------------------------------------------------
    // Address and result formation
    // ------------------------------------------------------------------------
    // PC reads four ahead, then bit 1 drops so the sum stays word aligned
    wire [31:0] pc_ahead  = INSN_ADDR_IN + `CLSD_PC_AHEAD;
    wire [31:0] pc_source = pc_ahead & ~(32'h00000001 << `CLSD_PC_BIT1);
    wire [31:0] lda_base  = bit_sel ? SP_VALUE_IN : pc_source;

    reg  [31:0] addr_c;
    reg  [1:0]  size_c;

    // Pick the base and scaled offset for each group
    always @* begin
        addr_c = `CLSD_RST_WORD;
        size_c = `CLSD_SIZE_WORD;
        if (is_imm) begin
            addr_c = RD_DATA_A_IN + (bit_byte ? off_byte : off_word);
            size_c = bit_byte ? `CLSD_SIZE_BYTE : `CLSD_SIZE_WORD;
        end else if (is_half) begin
            addr_c = RD_DATA_A_IN + off_half;
            size_c = `CLSD_SIZE_HALF;
        end else if (is_sp) begin
            addr_c = SP_VALUE_IN + off_w8;
        end else if (is_lda) begin
            addr_c = lda_base + off_w8;
        end
    end

    // Register file read selects follow the instruction directly
    always @* begin
        RD_SEL_A_OUT = base_reg_field;
        RD_SEL_B_OUT = low_eight_register;
    end

    // ------------------------------------------------------------------------
    // Store data lane placement
    // ------------------------------------------------------------------------
    reg  [31:0] wdata_c;
    reg  [3:0]  be_c;

    // Narrow stores replicate the low bits so any lane matches the address
    always @* begin
        wdata_c = RD_DATA_B_IN;
        be_c    = 4'hF;
        case (size_c)
            `CLSD_SIZE_BYTE: begin
                wdata_c = {4{RD_DATA_B_IN[7:0]}};
                be_c    = 4'h1 << addr_c[1:0];
            end
            `CLSD_SIZE_HALF: begin
                wdata_c = {2{RD_DATA_B_IN[15:0]}};
                be_c    = addr_c[1] ? 4'hC : 4'h3;
            end
            default: begin
                wdata_c = RD_DATA_B_IN;
                be_c    = 4'hF;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Load data extraction
    // ------------------------------------------------------------------------
    reg  [31:0] ldata_c;

    // Zero-extend byte and half-word loads from the addressed lane
    always @* begin
        ldata_c = MEM_RDATA_IN;
        case (MEM_SIZE_OUT)
            `CLSD_SIZE_BYTE: begin
                ldata_c = {24'h000000, MEM_RDATA_IN[8*MEM_ADDR_OUT[1:0] +: 8]};
            end
            `CLSD_SIZE_HALF: begin
                ldata_c = {16'h0000, MEM_RDATA_IN[16*MEM_ADDR_OUT[1] +: 16]};
            end
            default: begin
                ldata_c = MEM_RDATA_IN;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Handshake and flags
    // ------------------------------------------------------------------------
    // Only idle accepts; an illegal code is accepted and dropped
    assign INSN_READY_OUT   = (state_q == ST_IDLE);
    assign INSN_ILLEGAL_OUT = INSN_VALID_IN & INSN_READY_OUT & ~known;
    // None of these groups ever writes the condition flags
    assign FLAGS_WR_EN_OUT  = 1'b0;

    wire take = INSN_VALID_IN & INSN_READY_OUT & known;
    wire mem_op = is_imm | is_half | is_sp;

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    // Memory groups take request plus writeback, load-address one ALU cycle
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take && mem_op) begin
                    state_d = ST_MEM;
                end else if (take) begin
                    state_d = ST_WB;
                end
            end
            ST_MEM: begin
                if (MEM_DONE_IN) begin
                    state_d = ST_IDLE;
                end
            end
            ST_WB: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register
    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------------
    // Memory request and writeback registers
    // ------------------------------------------------------------------------
    reg        load_q;
    reg [2:0]  dest_q;
    reg [31:0] lda_q;

    // Capture the request when taken; hold it until memory finishes
    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            MEM_REQ_OUT     <= 1'b0;
            MEM_WRITE_OUT   <= 1'b0;
            MEM_SIZE_OUT    <= `CLSD_SIZE_WORD;
            MEM_BYTE_EN_OUT <= 4'h0;
            MEM_ADDR_OUT    <= `CLSD_RST_WORD;
            MEM_WDATA_OUT   <= `CLSD_RST_WORD;
            load_q          <= 1'b0;
            dest_q          <= 3'h0;
            lda_q           <= `CLSD_RST_WORD;
        end else begin
            if (take) begin
                MEM_REQ_OUT     <= mem_op;
                MEM_WRITE_OUT   <= mem_op & ~bit_load;
                MEM_SIZE_OUT    <= size_c;
                MEM_BYTE_EN_OUT <= (mem_op & ~bit_load) ? be_c : 4'h0;
                MEM_ADDR_OUT    <= addr_c;
                MEM_WDATA_OUT   <= wdata_c;
                load_q          <= mem_op & bit_load;
                dest_q          <= low_eight_register;
                lda_q           <= addr_c;
            end else if (state_q == ST_MEM && MEM_DONE_IN) begin
                MEM_REQ_OUT     <= 1'b0;
                MEM_WRITE_OUT   <= 1'b0;
                MEM_BYTE_EN_OUT <= 4'h0;
            end
        end
    end

    // Register write and completion pulse
    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            WR_EN_OUT   <= 1'b0;
            WR_SEL_OUT  <= 3'h0;
            WR_DATA_OUT <= `CLSD_RST_WORD;
            DONE_OUT    <= 1'b0;
        end else begin
            WR_EN_OUT <= 1'b0;
            DONE_OUT  <= 1'b0;
            if (state_q == ST_MEM && MEM_DONE_IN) begin
                WR_EN_OUT   <= load_q;
                WR_SEL_OUT  <= dest_q;
                WR_DATA_OUT <= ldata_c;
                DONE_OUT    <= 1'b1;
            end else if (state_q == ST_WB) begin
                WR_EN_OUT   <= 1'b1;
                WR_SEL_OUT  <= dest_q;
                WR_DATA_OUT <= lda_q;
                DONE_OUT    <= 1'b1;
            end
        end
    end

endmodule // clsd_decoder

`default_nettype wire

// file: tb/clsd_mem_model.sv
// Partner model: register file read ports, stack pointer and a memory with variable latency.
// Assumes the bench fills regs and sp_q between instructions and sets lat_in; one clock.
`timescale 1ns/1ps
`default_nettype none

module clsd_mem_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Register file read
    input  wire logic [2:0]  sel_a_in,
    input  wire logic [2:0]  sel_b_in,
    output logic      [31:0] data_a_out,
    output logic      [31:0] data_b_out,
    output logic      [31:0] sp_out,
    // Memory side
    input  wire logic        req_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [2:0]  lat_in,
    output logic             done_out,
    output logic      [31:0] rdata_out
);
    logic [31:0] regs [8];
    logic [31:0] sp_q;
    logic [31:0] junk_q = 32'hC3A55A3C;
    logic [2:0]  cnt_q;

    // Contents seen at an address
    function automatic logic [31:0] mfun(input logic [31:0] a);
        return (a * 32'h9E3779B1) ^ 32'h5A5A5A5A;
    endfunction

    // Reads answer at once; outside done a toggling pattern, so stale data never matches
    assign data_a_out = regs[sel_a_in];
    assign data_b_out = regs[sel_b_in];
    assign sp_out     = sp_q;
    assign rdata_out  = done_out ? mfun(addr_in) : junk_q;

    // Latency counter: done pulses once after lat_in waiting cycles
    always @(posedge clk_in) begin
        junk_q <= ~junk_q;
        if (!rst_n_in || !req_in || done_out) begin
            cnt_q    <= 3'h0;
            done_out <= 1'b0;
        end else if (cnt_q == lat_in) begin
            done_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
endmodule // clsd_mem_model

`default_nettype wire

// file: tb/clsd_decoder_chk.sv
// Checker for the compact load/store decoder: handshake timing and writeback relations.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module clsd_decoder_chk (
    // Clock, reset and fetch
    input wire logic        REF_CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        INSN_VALID_IN,
    input wire logic [15:0] INSN_IN,
    input wire logic        INSN_READY_OUT,
    input wire logic        INSN_ILLEGAL_OUT,
    // Writeback and memory
    input wire logic        WR_EN_OUT,
    input wire logic        FLAGS_WR_EN_OUT,
    input wire logic        DONE_OUT,
    input wire logic        MEM_REQ_OUT,
    input wire logic        MEM_WRITE_OUT,
    input wire logic [1:0]  MEM_SIZE_OUT,
    input wire logic        MEM_DONE_IN
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    // Taken instruction and its group
    wire take_w = INSN_VALID_IN && INSN_READY_OUT;
    wire lda_w  = INSN_IN[15:12] == 4'hA;
    wire mem_w  = INSN_IN[15:13] == 3'h3 || INSN_IN[15:12] == 4'h8 || INSN_IN[15:12] == 4'h9;

    sequence lda_wb_s; ##2 (DONE_OUT && WR_EN_OUT); endsequence
    sequence mem_end_s; ##1 (DONE_OUT && !MEM_REQ_OUT); endsequence

    lda_two_cycle_a: assert property (take_w && lda_w |-> lda_wb_s)
        else $error("load-address writeback not two cycles after take");
    lda_no_mem_a: assert property (take_w && lda_w |=> !MEM_REQ_OUT [*2])
        else $error("load-address touched memory");
    mem_start_a: assert property (take_w && mem_w |=> MEM_REQ_OUT && MEM_WRITE_OUT != $past(INSN_IN[11]))
        else $error("memory request or direction wrong after take");
    mem_finish_a: assert property (MEM_REQ_OUT && MEM_DONE_IN |-> mem_end_s)
        else $error("completion not one cycle after memory done");
    flags_still_a: assert property (take_w && lda_w |-> !FLAGS_WR_EN_OUT [*3])
        else $error("condition flags written");
    store_no_wb_a: assert property (MEM_REQ_OUT && MEM_WRITE_OUT && MEM_DONE_IN |=> !WR_EN_OUT)
        else $error("store wrote a register");
    load_wb_a: assert property (MEM_REQ_OUT && !MEM_WRITE_OUT && MEM_DONE_IN |=> WR_EN_OUT)
        else $error("load did not write its register");
    half_size_a: assert property (take_w && INSN_IN[15:12] == 4'h8 |=> MEM_SIZE_OUT == 2'h1)
        else $error("half-word size wrong");
    size_sel_a: assert property (take_w && INSN_IN[15:13] == 3'h3 |=> MEM_SIZE_OUT == ($past(INSN_IN[12]) ? 2'h0 : 2'h2))
        else $error("immediate group size wrong");
    illegal_drop_a: assert property (INSN_ILLEGAL_OUT |=> !MEM_REQ_OUT && INSN_READY_OUT)
        else $error("unknown group was not dropped");
endmodule // clsd_decoder_chk

bind clsd_decoder clsd_decoder_chk chk (.*);

`default_nettype wire

// file: tb/compact_load_store_decoder_tb.sv
// Self-checking bench for the compact load/store decoder: random instructions of all groups.
// Assumes the decoder, its checker bind and the partner model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module compact_load_store_decoder_tb;
    logic        clk, rst_n, valid, ready, illegal, wr_en, flags_wr, mreq, mwr, mdone, done;
    logic [15:0] insn;
    logic [31:0] iaddr, rda, rdb, sp, wdata, maddr, mwdata, mrdata;
    logic [2:0]  sela, selb, wsel, lat;
    logic [1:0]  msize;
    logic [3:0]  mbe;
    logic [3:0]  bad [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
    int          fail_count = 0;
    int          total_checks = 0;

    clsd_decoder dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .INSN_VALID_IN(valid), .INSN_IN(insn),
        .INSN_ADDR_IN(iaddr), .INSN_READY_OUT(ready), .INSN_ILLEGAL_OUT(illegal), .RD_SEL_A_OUT(sela),
        .RD_SEL_B_OUT(selb), .RD_DATA_A_IN(rda), .RD_DATA_B_IN(rdb), .SP_VALUE_IN(sp), .WR_EN_OUT(wr_en),
        .WR_SEL_OUT(wsel), .WR_DATA_OUT(wdata), .FLAGS_WR_EN_OUT(flags_wr), .MEM_REQ_OUT(mreq),
        .MEM_WRITE_OUT(mwr), .MEM_SIZE_OUT(msize), .MEM_BYTE_EN_OUT(mbe), .MEM_ADDR_OUT(maddr),
        .MEM_WDATA_OUT(mwdata), .MEM_DONE_IN(mdone), .MEM_RDATA_IN(mrdata), .DONE_OUT(done));
    clsd_mem_model mm (.clk_in(clk), .rst_n_in(rst_n), .sel_a_in(sela), .sel_b_in(selb), .data_a_out(rda),
        .data_b_out(rdb), .sp_out(sp), .req_in(mreq), .addr_in(maddr), .lat_in(lat), .done_out(mdone),
        .rdata_out(mrdata));

    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish;
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One instruction: reference result worked out first, then driven and compared
    task automatic run(input logic [15:0] op);
        logic [31:0] ea, res, rd, mask;
        logic [3:0]  g;
        logic [2:0]  ri;
        logic [1:0]  sz;
        logic        st, saw;
        int          k;
        g    = op[15:12];
        ri   = (g == 4'h9 || g == 4'hA) ? op[10:8] : op[2:0];
        rd   = mm.regs[ri];
        sz   = (g[3:1] == 3'h3 && op[12]) ? 2'h0 : (g == 4'h8) ? 2'h1 : 2'h2;
        st   = g != 4'hA && !op[11];
        mask = sz == 2'h0 ? 32'h000000FF : sz == 2'h1 ? 32'h0000FFFF : 32'hFFFFFFFF;
        if (g == 4'h9) ea = mm.sp_q + {22'h0, op[7:0], 2'h0};
        else if (g == 4'h8) ea = mm.regs[op[5:3]] + {26'h0, op[10:6], 1'h0};
        else ea = mm.regs[op[5:3]] + (op[12] ? {27'h0, op[10:6]} : {25'h0, op[10:6], 2'h0});
        res  = (mm.mfun(ea) >> (sz == 2'h2 ? 5'h0 : {ea[1:0], 3'h0})) & mask;
        if (g == 4'hA) res = (op[11] ? mm.sp_q : ((iaddr + 32'h4) & ~32'h2)) + {22'h0, op[7:0], 2'h0};
        valid = 1'b1;
        insn  = op;
        @(posedge clk);
        #1 valid = 1'b0;
        saw = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++) begin
            if (k == 0) `CHK(ready, 1'b0)
            if (mreq === 1'b1) saw = 1'b1;
            if (mreq === 1'b1 && mdone === 1'b1) begin
                `CHK(maddr, ea)
                `CHK(msize, sz)
                `CHK(mwr, st)
                `CHK(mbe, !st ? 4'h0 : sz == 2'h0 ? 4'h1 << ea[1:0] : sz == 2'h1 ? (ea[1] ? 4'hC : 4'h3) : 4'hF)
                if (st) `CHK(mwdata, sz == 2'h0 ? {4{rd[7:0]}} : sz == 2'h1 ? {2{rd[15:0]}} : rd)
            end
            @(posedge clk);
            #1;
        end
        if (k == 40) fail_count++;
        `CHK(ready, 1'b1)
        `CHK(saw, g != 4'hA)
        `CHK(flags_wr, 1'b0)
        `CHK(wr_en, !st)
        if (!st) `CHK(wsel, ri)
        if (!st) `CHK(wdata, res)
    endtask

    // Reset, random instructions of every group, then unknown groups
    initial begin
        int          i;
        logic [15:0] op;
        rst_n = 1'b0;
        valid = 1'b0;
        insn  = 16'h0000;
        iaddr = 32'h00000000;
        lat   = 3'h0;
        void'($urandom(71));
        for (i = 0; i < 8; i++) mm.regs[i] = $urandom & ~32'h3;
        mm.sp_q = $urandom & ~32'h3;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        for (i = 0; i < 240; i++) begin
            op = $urandom;
            if (i % 4 == 0) op[15:13] = 3'h3;
            else op[15:12] = 4'h7 + (i % 4);
            if (i < 8) op[10:0] = 11'h7FF;
            iaddr = $urandom & ~32'h1;
            lat   = $urandom % 5;
            mm.regs[$urandom % 8] = $urandom & ~32'h3;
            mm.sp_q = $urandom & ~32'h3;
            run(op);
        end
        // Valid stays up across the unknown codes: each is dropped in one cycle
        valid = 1'b1;
        foreach (bad[j]) begin
            insn  = {bad[j], 12'($urandom)};
            #1 `CHK(illegal, 1'b1)
            @(posedge clk);
            #1 `CHK(mreq, 1'b0)
        end
        valid = 1'b0;
        tally_and_finish;
    end

    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish;
    end
endmodule // compact_load_store_decoder_tb

`default_nettype wire
